// ===== src/igmp_snoop_pkg.sv
`default_nettype none
package igmp_snoop_pkg;
  // --------------------------------------------------------------
  // message type codes
  // --------------------------------------------------------------
  localparam logic [7:0] TYPE_QUERY = 8'h11; // general or group query
  localparam logic [7:0] TYPE_REPORT_V2 = 8'h16; // version 2 join
  localparam logic [7:0] TYPE_LEAVE_V2 = 8'h17; // version 2 leave
  localparam logic [7:0] TYPE_REPORT_V1 = 8'h12; // version 1 join
  // --------------------------------------------------------------
  // sizes and reset values
  // --------------------------------------------------------------
  localparam int GROUP_W = 32; // ipv4 group address width
  localparam int CNT_W = 8; // per-port group count width
  localparam int LIM_W = 7; // per-port limit width
  localparam int PORTS_DEF = 10; // ports served
  localparam int PORT_W_DEF = 4; // port number width
  localparam int ENTRIES_DEF = 64; // shared membership slots, at most 255
  localparam logic [LIM_W-1:0] LIMIT_MAX = 7'h64; // largest legal cap
  localparam logic [LIM_W-1:0] LIMIT_RST = 7'h00; // cap value after reset
  localparam logic LIMIT_OFF_RST = 1'b1; // cap disabled after reset
  localparam logic SNOOP_RST = 1'b0; // snooping off after reset
  localparam logic [CNT_W-1:0] CNT_ONE = 8'h01; // count step
  // --------------------------------------------------------------
  // message classes
  // --------------------------------------------------------------
  typedef enum logic [2:0] {
    KIND_OTHER = 3'b000,
    KIND_GEN_QUERY = 3'b001,
    KIND_GRP_QUERY = 3'b010,
    KIND_REPORT_V2 = 3'b011,
    KIND_REPORT_V1 = 3'b100,
    KIND_LEAVE = 3'b101
  } msg_kind_t;
endpackage
`default_nettype wire

// ===== src/grp_tbl_if.sv
`timescale 1ns/1ns
`default_nettype none
// lookup and update path between the snoop control and the table
interface grp_tbl_if #(parameter int PORT_W = 4);
  logic [PORT_W-1:0] port; // port of the message
  logic [igmp_snoop_pkg::GROUP_W-1:0] group; // group of the message
  logic insert; // learn the pair at the next edge
  logic remove; // forget the pair at the next edge
  logic flush; // forget everything
  logic hit; // pair is held
  logic full; // no free slot
  modport ctrl (output port, group, insert, remove, flush, input hit, full);
  modport store (input port, group, insert, remove, flush, output hit, full);
endinterface
`default_nettype wire

// ===== src/igmp_group_table.sv
`timescale 1ns/1ns
`default_nettype none
module igmp_group_table #(
  parameter int ENTRIES = 64,
  parameter int PORT_W = 4
) (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // lookup and update
  grp_tbl_if.store tbl
);
  import igmp_snoop_pkg::*;

  // --------------------------------------------------------------
  // storage
  // --------------------------------------------------------------
  logic [ENTRIES-1:0] used_ff; // slot holds a membership
  logic [PORT_W-1:0] owner_ff [ENTRIES]; // port of each slot
  logic [GROUP_W-1:0] addr_ff [ENTRIES]; // group of each slot
  logic [ENTRIES-1:0] match; // slot equals the looked-up pair
  logic [ENTRIES-1:0] free_vec; // lowest free slot, one-hot
  logic [ENTRIES-1:0] nxt_used; // next slot occupancy

  // --------------------------------------------------------------
  // content match, one comparator per slot
  // --------------------------------------------------------------
  for (genvar i = 0; i < ENTRIES; i++) begin : g_match
    assign match[i] = used_ff[i] && (owner_ff[i] == tbl.port) && (addr_ff[i] == tbl.group);
  end
  assign tbl.hit = |match;
  assign tbl.full = &used_ff;
  // lowest clear bit; the carry of +1 stops there
  assign free_vec = ~used_ff & (used_ff + {{(ENTRIES-1){1'b0}}, 1'b1});
  assign nxt_used = (used_ff | (tbl.insert ? free_vec : '0)) & ~(tbl.remove ? match : '0);

  // occupancy, the only control state here
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      used_ff <= '0;
    end else if (tbl.flush) begin
      used_ff <= '0;
    end else begin
      used_ff <= nxt_used;
    end
  end

  // slot contents carry no reset; unused slots are never matched
  always_ff @(posedge clock) begin
    for (int i = 0; i < ENTRIES; i++) begin
      if (tbl.insert && free_vec[i]) begin
        owner_ff[i] <= tbl.port;
        addr_ff[i] <= tbl.group;
      end
    end
  end

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  property p_leave_frees_slot;
    @(posedge clock) disable iff (!resetn)
    tbl.remove && tbl.hit && !tbl.flush |=>
      $countones(used_ff) == $countones($past(used_ff)) - 1;
  endproperty
  a_leave_frees_slot: assert property (p_leave_frees_slot)
    else $error("leave did not free exactly one slot");

  property p_learn_takes_slot;
    @(posedge clock) disable iff (!resetn)
    tbl.insert && !tbl.full && !tbl.flush |=>
      $countones(used_ff) == $countones($past(used_ff)) + 1;
  endproperty
  a_learn_takes_slot: assert property (p_learn_takes_slot)
    else $error("learning did not take exactly one slot");
endmodule
`default_nettype wire

// ===== src/igmp_snoop_port_group_limit.sv
`timescale 1ns/1ns
`default_nettype none
module igmp_snoop_port_group_limit #(
  parameter int PORTS = igmp_snoop_pkg::PORTS_DEF,
  parameter int PORT_W = igmp_snoop_pkg::PORT_W_DEF,
  parameter int ENTRIES = igmp_snoop_pkg::ENTRIES_DEF
) (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // parsed message, one cycle per message
  input wire logic msg_valid,
  input wire logic [7:0] msg_type,
  input wire logic [igmp_snoop_pkg::GROUP_W-1:0] msg_group,
  input wire logic [PORT_W-1:0] msg_port,
  // snooping status from management
  input wire logic snoop_sel,
  input wire logic snoop_commit,
  // per-port cap from management
  input wire logic lim_wr,
  input wire logic [PORT_W-1:0] lim_port,
  input wire logic lim_off,
  input wire logic [igmp_snoop_pkg::LIM_W-1:0] lim_value,
  // verdict, one cycle after the message
  output logic res_valid,
  output igmp_snoop_pkg::msg_kind_t res_kind,
  output logic res_forward,
  output logic res_learned,
  // status
  output logic snoop_active,
  output logic lim_reject
);
  import igmp_snoop_pkg::*;

  // --------------------------------------------------------------
  // state
  // --------------------------------------------------------------
  logic snoop_ff; // snooping in force
  logic [LIM_W-1:0] lim_ff [PORTS]; // cap per port
  logic [PORTS-1:0] lim_off_ff; // cap disabled per port
  logic [CNT_W-1:0] cnt_ff [PORTS]; // groups held per port
  logic res_valid_ff;
  msg_kind_t res_kind_ff;
  logic res_forward_ff;
  logic res_learned_ff;
  logic lim_reject_ff;

  grp_tbl_if #(.PORT_W(PORT_W)) tbl ();

  igmp_group_table #(.ENTRIES(ENTRIES), .PORT_W(PORT_W)) u_table (
    .clock(clock),
    .resetn(resetn),
    .tbl(tbl)
  );

  // --------------------------------------------------------------
  // classification
  // --------------------------------------------------------------
  wire grp_zero = (msg_group == '0); // all-zero group address
  msg_kind_t kind; // class of the incoming message
  assign kind = (msg_type == TYPE_QUERY) ? (grp_zero ? KIND_GEN_QUERY : KIND_GRP_QUERY) :
                (msg_type == TYPE_REPORT_V2) ? KIND_REPORT_V2 :
                (msg_type == TYPE_REPORT_V1) ? KIND_REPORT_V1 :
                (msg_type == TYPE_LEAVE_V2) ? KIND_LEAVE : KIND_OTHER;
  wire is_join = msg_valid && (kind == KIND_REPORT_V2 || kind == KIND_REPORT_V1);
  // version 1 hosts leave silently, so only type 17h removes an entry
  wire is_leave = msg_valid && (kind == KIND_LEAVE);

  // --------------------------------------------------------------
  // admission against the port cap
  // --------------------------------------------------------------
  wire port_ok = (32'(msg_port) < PORTS); // message port exists
  wire learn = snoop_ff && port_ok; // membership tracking applies
  wire [CNT_W-1:0] cur_cnt = port_ok ? cnt_ff[msg_port] : '0;
  wire [LIM_W-1:0] cur_lim = port_ok ? lim_ff[msg_port] : '0;
  wire cur_off = port_ok ? lim_off_ff[msg_port] : LIMIT_OFF_RST;
  // disabled cap admits all; zero cap admits none
  wire under_cap = cur_off || ({1'b0, cur_lim} > cur_cnt);
  wire new_join = is_join && learn && !tbl.hit; // join for an unheld group
  wire do_insert = new_join && under_cap && !tbl.full;
  wire join_drop = new_join && !(under_cap && !tbl.full);
  wire do_remove = is_leave && learn && tbl.hit;
  wire do_flush = snoop_commit && !snoop_sel; // disabling forgets all groups

  assign tbl.port = msg_port;
  assign tbl.group = msg_group;
  assign tbl.insert = do_insert;
  assign tbl.remove = do_remove;
  assign tbl.flush = do_flush;

  // a cap write is refused when an enabled cap is out of range or for a missing port
  wire lim_ok = lim_wr && (32'(lim_port) < PORTS) && (lim_off || (lim_value <= LIMIT_MAX));

  // --------------------------------------------------------------
  // snooping status: only an explicit commit changes it
  // --------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      snoop_ff <= SNOOP_RST;
    end else if (snoop_commit) begin
      snoop_ff <= snoop_sel;
    end
  end

  // --------------------------------------------------------------
  // per-port caps and counts
  // --------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      lim_off_ff <= {PORTS{LIMIT_OFF_RST}};
      for (int p = 0; p < PORTS; p++) begin
        lim_ff[p] <= LIMIT_RST;
      end
    end else if (lim_ok) begin
      lim_off_ff[lim_port] <= lim_off;
      lim_ff[lim_port] <= lim_value;
    end
  end

  // lowering a cap keeps existing members; only new joins feel it
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      for (int p = 0; p < PORTS; p++) begin
        cnt_ff[p] <= '0;
      end
    end else begin
      for (int p = 0; p < PORTS; p++) begin
        if (do_flush) begin
          cnt_ff[p] <= '0;
        end else if (do_insert && 32'(msg_port) == p) begin
          cnt_ff[p] <= cnt_ff[p] + CNT_ONE;
        end else if (do_remove && 32'(msg_port) == p) begin
          cnt_ff[p] <= cnt_ff[p] - CNT_ONE;
        end
      end
    end
  end

  // --------------------------------------------------------------
  // verdict registers
  // --------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      res_valid_ff <= 1'b0;
      res_kind_ff <= KIND_OTHER;
      res_forward_ff <= 1'b0;
      res_learned_ff <= 1'b0;
      lim_reject_ff <= 1'b0;
    end else begin
      res_valid_ff <= msg_valid;
      res_kind_ff <= msg_valid ? kind : KIND_OTHER;
      res_forward_ff <= msg_valid && !join_drop;
      res_learned_ff <= do_insert;
      lim_reject_ff <= lim_wr && !lim_ok;
    end
  end

  assign res_valid = res_valid_ff;
  assign res_kind = res_kind_ff;
  assign res_forward = res_forward_ff;
  assign res_learned = res_learned_ff;
  assign snoop_active = snoop_ff;
  assign lim_reject = lim_reject_ff;

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  property p_gen_query;
    @(posedge clock) disable iff (!resetn)
    msg_valid && msg_type == 8'h11 && msg_group == '0 |=> res_valid && res_kind == KIND_GEN_QUERY;
  endproperty
  a_gen_query: assert property (p_gen_query)
    else $error("general query misclassified");

  property p_grp_query;
    @(posedge clock) disable iff (!resetn)
    msg_valid && msg_type == 8'h11 && msg_group != '0 |=> res_kind == KIND_GRP_QUERY;
  endproperty
  a_grp_query: assert property (p_grp_query)
    else $error("group query misclassified");

  property p_report_kind;
    @(posedge clock) disable iff (!resetn)
    msg_valid && (msg_type == 8'h16 || msg_type == 8'h12) |=>
      res_kind == ($past(msg_type) == 8'h16 ? KIND_REPORT_V2 : KIND_REPORT_V1);
  endproperty
  a_report_kind: assert property (p_report_kind)
    else $error("report misclassified");

  property p_leave_kind;
    @(posedge clock) disable iff (!resetn)
    msg_valid && msg_type == 8'h17 |=> res_kind == KIND_LEAVE && res_forward;
  endproperty
  a_leave_kind: assert property (p_leave_kind)
    else $error("leave misclassified");

  property p_snoop_commit_only;
    @(posedge clock) disable iff (!resetn)
    snoop_ff != $past(snoop_ff) |-> $past(snoop_commit) && snoop_ff == $past(snoop_sel);
  endproperty
  a_snoop_commit_only: assert property (p_snoop_commit_only)
    else $error("snooping status changed without commit");

  property p_no_cap_accepts;
    @(posedge clock) disable iff (!resetn)
    is_join && learn && cur_off && !tbl.full |=> res_forward;
  endproperty
  a_no_cap_accepts: assert property (p_no_cap_accepts)
    else $error("join dropped with cap disabled");

  property p_zero_cap;
    @(posedge clock) disable iff (!resetn)
    new_join && !cur_off && cur_lim == '0 |=> !res_forward && !res_learned;
  endproperty
  a_zero_cap: assert property (p_zero_cap)
    else $error("zero cap admitted a group");

  property p_cap_drop;
    @(posedge clock) disable iff (!resetn)
    new_join && !cur_off && {1'b0, cur_lim} <= cur_cnt && !do_flush |=>
      !res_forward && cnt_ff[$past(msg_port)] == $past(cur_cnt);
  endproperty
  a_cap_drop: assert property (p_cap_drop)
    else $error("join beyond cap not dropped");

  property p_leave_count;
    @(posedge clock) disable iff (!resetn)
    do_remove && !do_flush |=> cnt_ff[$past(msg_port)] == $past(cur_cnt) - CNT_ONE;
  endproperty
  a_leave_count: assert property (p_leave_count)
    else $error("leave did not decrement the port count");

  property p_refresh;
    @(posedge clock) disable iff (!resetn)
    is_join && learn && tbl.hit && !do_flush |=>
      res_forward && !res_learned && cnt_ff[$past(msg_port)] == $past(cur_cnt);
  endproperty
  a_refresh: assert property (p_refresh)
    else $error("repeat join consumed a slot");
endmodule
`default_nettype wire

// ===== tb/igmp_peer_model.sv
`timescale 1ns/1ns
`default_nettype none
// --------------------------------------------------------------
// hosts and routers on the far side of the snoop logic
// --------------------------------------------------------------
module igmp_peer_model #(
  parameter int PORT_W = 4
) (
  // parsed message toward the snoop logic
  output logic msg_valid,
  output logic [7:0] msg_type,
  output logic [igmp_snoop_pkg::GROUP_W-1:0] msg_group,
  output logic [PORT_W-1:0] msg_port
);
  import igmp_snoop_pkg::*;
  // lines start quiet
  initial begin
    msg_valid = 1'b0;
    msg_type = 8'h00;
    msg_group = '0;
    msg_port = '0;
  end
  // one message per call; the bench times the call just after a falling edge
  // routers poll members with general queries to the all-hosts group
  // queries leave with ttl one, so only this segment sees them
  // an unanswered group is dropped by the router, never fed again
  task automatic send(input logic [7:0] t, input logic [GROUP_W-1:0] g,
                      input logic [PORT_W-1:0] p);
    msg_valid = 1'b1;
    msg_type = t;
    msg_group = g;
    msg_port = p;
  endtask
  // released lines do not keep the last value, so stale data cannot pass
  // a version 1 host leaving just goes quiet here, nothing is sent
  task automatic release_lines();
    msg_valid = 1'b0;
    msg_type = ~msg_type;
    msg_group = ~msg_group;
    msg_port = ~msg_port;
  endtask
endmodule
`default_nettype wire

// ===== tb/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import igmp_snoop_pkg::*;
  // --------------------------------------------------------------
  // setup; small table so that it fills during the run
  // --------------------------------------------------------------
  localparam int NP = 10;
  localparam int NE = 16;
  logic clock, resetn, snoop_sel, snoop_commit, lim_wr, lim_off;
  logic [3:0] lim_port;
  logic [LIM_W-1:0] lim_value;
  wire logic msg_valid;
  wire logic [7:0] msg_type;
  wire logic [GROUP_W-1:0] msg_group;
  wire logic [3:0] msg_port;
  logic res_valid, res_forward, res_learned, snoop_active, lim_reject;
  msg_kind_t res_kind;
  int num_errors, tests_run, cycles;
  // reference state of snooping, caps, counts and held pairs
  bit snoop_m;
  bit off_m[16];
  int cap_m[16];
  int cnt_m[16];
  int total_m;
  bit held[logic [35:0]];
  logic pend; // a verdict is due at the next falling edge
  logic [4:0] exp_res; // kind, forward, learned
  logic [7:0] tcodes[6] = '{8'h11, 8'h11, 8'h16, 8'h12, 8'h17, 8'h33};

  igmp_peer_model #(.PORT_W(4)) u_igmp_peer_model (.msg_valid(msg_valid),
    .msg_type(msg_type), .msg_group(msg_group), .msg_port(msg_port));
  igmp_snoop_port_group_limit #(.PORTS(NP), .PORT_W(4), .ENTRIES(NE))
    u_igmp_snoop_port_group_limit (.clock(clock), .resetn(resetn),
    .msg_valid(msg_valid), .msg_type(msg_type), .msg_group(msg_group),
    .msg_port(msg_port), .snoop_sel(snoop_sel), .snoop_commit(snoop_commit),
    .lim_wr(lim_wr), .lim_port(lim_port), .lim_off(lim_off), .lim_value(lim_value),
    .res_valid(res_valid), .res_kind(res_kind), .res_forward(res_forward),
    .res_learned(res_learned), .snoop_active(snoop_active), .lim_reject(lim_reject));

  // --------------------------------------------------------------
  // clock and hang guard
  // --------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // generous ceiling, the run needs about seven hundred cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      report_and_stop();
    end
  end

  // --------------------------------------------------------------
  // reference functions and tasks
  // --------------------------------------------------------------
  function automatic msg_kind_t kind_of(logic [7:0] t, logic [31:0] g);
    case (t)
      8'h11: return (g == 32'h0) ? KIND_GEN_QUERY : KIND_GRP_QUERY;
      8'h16: return KIND_REPORT_V2;
      8'h12: return KIND_REPORT_V1;
      8'h17: return KIND_LEAVE;
      default: return KIND_OTHER;
    endcase
  endfunction
  // verdict of one message; updates the reference state as the design must
  function automatic logic [4:0] predict(logic [7:0] t, logic [31:0] g, logic [3:0] p);
    msg_kind_t k;
    logic [35:0] key;
    logic f;
    logic l;
    k = kind_of(t, g);
    key = {p, g};
    f = 1'b1;
    l = 1'b0;
    if (snoop_m && p < NP) begin
      if (k == KIND_REPORT_V2 || k == KIND_REPORT_V1) begin
        if (held.exists(key)) begin
          f = 1'b1; // refresh only
        end else if ((!off_m[p] && cnt_m[p] >= cap_m[p]) || total_m >= NE) begin
          f = 1'b0;
        end else begin
          held[key] = 1'b1;
          cnt_m[p]++;
          total_m++;
          l = 1'b1;
        end
      end else if (k == KIND_LEAVE && held.exists(key)) begin
        held.delete(key);
        cnt_m[p]--;
        total_m--;
      end
    end
    return {k, f, l};
  endfunction
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // next falling edge; the previous message's verdict must stand now
  task automatic tick();
    @(negedge clock);
    check("res_valid", res_valid, pend);
    if (pend) begin
      check("res_kind", res_kind, exp_res[4:2]);
      check("res_forward", res_forward, exp_res[1]);
      check("res_learned", res_learned, exp_res[0]);
    end
    pend = 1'b0;
  endtask
  task automatic msg(input logic [7:0] t, input logic [31:0] g, input logic [3:0] p);
    tick();
    exp_res = predict(t, g, p);
    pend = 1'b1;
    u_igmp_peer_model.send(t, g, p);
  endtask
  task automatic idle();
    tick();
    u_igmp_peer_model.release_lines();
  endtask
  // commit a snooping status; turning it off empties the table
  task automatic snoop(input logic s);
    idle();
    snoop_sel = s;
    snoop_commit = 1'b1;
    tick();
    snoop_commit = 1'b0;
    snoop_sel = ~s;
    snoop_m = s;
    if (!s) begin
      held.delete();
      cnt_m = '{default: 0};
      total_m = 0;
    end
    check("snoop_active", snoop_active, s);
  endtask
  task automatic limit(input logic [3:0] p, input logic off, input logic [6:0] v);
    logic bad;
    idle();
    lim_wr = 1'b1;
    lim_port = p;
    lim_off = off;
    lim_value = v;
    tick();
    lim_wr = 1'b0;
    bad = (p >= NP) || (!off && v > 7'h64);
    check("lim_reject", lim_reject, bad);
    if (!bad) begin
      off_m[p] = off;
      cap_m[p] = v;
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    resetn = 1'b0;
    {snoop_sel, snoop_commit, lim_wr, pend} = 4'h0;
    lim_off = 1'b1;
    lim_port = 4'h0;
    lim_value = 7'h00;
    num_errors = 0;
    tests_run = 0;
    cycles = 0;
    total_m = 0;
    snoop_m = 1'b0;
    off_m = '{default: 1'b1};
    cap_m = '{default: 0};
    cnt_m = '{default: 0};
    void'($urandom(60));
    repeat (4) @(posedge clock);
    @(negedge clock);
    resetn = 1'b1;
    idle();
    check("snoop_active", snoop_active, 1'b0);
    // every type code, first with snooping off, then on with the default cap
    for (int i = 0; i < 6; i++) msg(tcodes[i], (i == 0) ? 32'h0 : 32'he0000100 + i, 4'h1);
    snoop(1'b1);
    for (int i = 0; i < 6; i++) msg(tcodes[i], (i == 0) ? 32'h0 : 32'he0000100 + i, 4'h1);
    for (int i = 0; i < 12; i++) msg(8'h16, 32'he0010000 + i, 4'h3);
    // a disabling commit empties the table
    snoop(1'b0);
    snoop(1'b1);
    // cap of four, six joins back to back
    limit(4'h2, 1'b0, 7'h04);
    for (int i = 0; i < 6; i++) msg(8'h16, 32'he0020000 + i, 4'h2);
    msg(8'h12, 32'he0020001, 4'h2);
    msg(8'h17, 32'he0020000, 4'h2);
    msg(8'h16, 32'he0020005, 4'h2);
    // boundary caps and refused writes
    limit(4'h5, 1'b0, 7'h00);
    msg(8'h16, 32'he0030000, 4'h5);
    limit(4'h5, 1'b0, 7'h64);
    limit(4'h5, 1'b0, 7'h65);
    limit(4'hc, 1'b1, 7'h00);
    msg(8'h12, 32'he0030000, 4'h5);
    // random traffic with occasional cap and status changes
    for (int n = 0; n < 600; n++) begin
      int r;
      r = $urandom_range(0, 39);
      if (r == 0)
        limit($urandom_range(0, 11), $urandom_range(0, 3) == 0,
              ($urandom_range(0, 9) == 0) ? $urandom_range(95, 127) : $urandom_range(0, 6));
      else if (r == 1)
        snoop($urandom_range(0, 4) != 0);
      else if (r == 2)
        idle();
      else
        msg(tcodes[$urandom_range(0, 5)], ($urandom_range(0, 7) == 0) ? 32'h0 :
            32'he0400000 + $urandom_range(1, 7), $urandom_range(0, 11));
    end
    // mid-run reset: snooping off, caps disabled and table empty again
    idle();
    resetn = 1'b0;
    @(negedge clock);
    resetn = 1'b1;
    snoop_m = 1'b0;
    off_m = '{default: 1'b1};
    cnt_m = '{default: 0};
    total_m = 0;
    held.delete();
    idle();
    check("snoop_active", snoop_active, 1'b0);
    snoop(1'b1);
    // port 2 had a cap of four before; after reset all six are learned
    for (int i = 0; i < 6; i++) msg(8'h16, 32'he0050000 + i, 4'h2);
    idle();
    idle();
    report_and_stop();
  end
endmodule
`default_nettype wire
